// *** design/squib_port_pkg.sv ***
// constants and types for the squib serial command port
package squib_port_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] chan_t;
   typedef logic [3:0] count_t;
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_ARMED = 2'b01
   } seq_state_t;
   localparam int     PIN_W        = 5;
   localparam int     PIN_CS       = 0;
   localparam int     PIN_SCLK     = 1;
   localparam int     PIN_MOSI     = 2;
   localparam int     PIN_FEN_ONE  = 3;
   localparam int     PIN_FEN_TWO  = 4;
   localparam logic [4:0] PIN_RESET = 5'h01;
   localparam int     CHAN_W       = 4;
   localparam int     ID_BIT_POS   = 7;
   localparam count_t CNT_RESET    = 4'h0;
   localparam count_t CNT_FULL     = 4'h8;
   localparam count_t CNT_OVER     = 4'h9;
   localparam count_t CNT_STEP     = 4'h1;
   localparam byte_t  BYTE_RESET   = 8'h00;
   localparam byte_t  CMD_NOP      = 8'h00;
   localparam byte_t  CMD_ECHO     = 8'h96;
   localparam byte_t  ECHO_REPLY   = 8'h69;
   localparam byte_t  CMD_ID_QUERY = 8'hC8;
   localparam byte_t  CMD_CONT     = 8'hC2;
   localparam byte_t  DIAG_C_LO    = 8'hC1;
   localparam byte_t  DIAG_C_HI    = 8'hC3;
   localparam byte_t  CMD_DIAG_C9  = 8'hC9;
   localparam byte_t  DIAG_D_LO    = 8'hD0;
   localparam byte_t  DIAG_D_HI    = 8'hD3;
   localparam byte_t  DIAG_E_LO    = 8'hE0;
   localparam byte_t  DIAG_E_HI    = 8'hE3;
   localparam byte_t  CMD_DIAG_E8  = 8'hE8;
   localparam byte_t  CMD_DIAG_E9  = 8'hE9;
   localparam byte_t  CMD_ARM_ONE  = 8'hA0;
   localparam byte_t  CMD_ARM_TWO  = 8'hA1;
   localparam byte_t  CMD_ARM_ALL  = 8'hA2;
   localparam logic [3:0] FIRE_NIBBLE = 4'h5;
   localparam chan_t  CHAN_NONE    = 4'h0;
   localparam chan_t  GROUP_ONE    = 4'h3;
   localparam chan_t  GROUP_TWO    = 4'hC;
   localparam chan_t  CHAN_ALL     = 4'hF;
   localparam logic   FOUR_CHANNEL_ID = 1'b0;
endpackage

// *** design/serial_frame_if.sv ***
// frame strobes and data between command logic and shift register
`timescale 1ns/100ps
`default_nettype none
interface serial_frame_if;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_fall;
   logic       mosi;
   logic       load_en;
   logic [7:0] load_byte;
   logic [7:0] rx_byte;
   logic       tx_bit;
   logic [3:0] bit_count;
   modport ctrl (output sclk_rise, sclk_fall, cs_fall, mosi, load_en,
                 load_byte, input rx_byte, tx_bit, bit_count);
   modport shifter (input sclk_rise, sclk_fall, cs_fall, mosi, load_en,
                    load_byte, output rx_byte, tx_bit, bit_count);
endinterface
`default_nettype wire

// *** design/pin_filter.sv ***
// three-stage synchroniser with agreement filter per pin
`timescale 1ns/100ps
`default_nettype none
module pin_filter #(
   parameter int             W         = 1,
   parameter logic [W-1:0]   RESET_VAL = '0
) (
   input  wire logic         clock,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] pin_in,
   output wire logic [W-1:0] level_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic [2:0] stage_q;
         logic       level_q;
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               stage_q <= {3{RESET_VAL[i]}};
               level_q <= RESET_VAL[i];
            end else begin
               stage_q <= {stage_q[1:0], pin_in[i]};
               if (stage_q[1] == stage_q[2]) begin
                  level_q <= stage_q[2];
               end
            end
         end
         assign level_out[i] = level_q;
      end
   endgenerate
endmodule
`default_nettype wire

// *** design/frame_shifter.sv ***
// eight-bit receive and transmit shift registers with bit counter
`timescale 1ns/100ps
`default_nettype none
module frame_shifter (
   input  wire logic       clock,
   input  wire logic       reset_n,
   serial_frame_if.shifter fr
);
   import squib_port_pkg::*;
   byte_t  rx_q;
   byte_t  tx_q;
   count_t cnt_q;
   // (R1) sample on rise
   always_ff @(posedge clock) begin
      if (!reset_n) rx_q <= BYTE_RESET;
      else if (fr.sclk_rise) rx_q <= {rx_q[6:0], fr.mosi};
   end
   // (R2) shift on fall, rotating so held data survives
   always_ff @(posedge clock) begin
      if (!reset_n) tx_q <= BYTE_RESET;
      else if (fr.cs_fall && fr.load_en) tx_q <= fr.load_byte;
      else if (fr.sclk_fall) tx_q <= {tx_q[6:0], tx_q[7]};
   end
   // (R14) count rises per frame
   always_ff @(posedge clock) begin
      if (!reset_n) cnt_q <= CNT_RESET;
      else if (fr.cs_fall) cnt_q <= CNT_RESET;
      else if (fr.sclk_rise && cnt_q != CNT_OVER) cnt_q <= cnt_q + CNT_STEP;
   end
   assign fr.rx_byte   = rx_q;
   assign fr.tx_bit    = tx_q[7];
   assign fr.bit_count = cnt_q;
   property p_sample_rise;
      @(posedge clock) disable iff (!reset_n)
      fr.sclk_rise |=> rx_q[0] == $past(fr.mosi);
   endproperty
   a_sample_rise: assert property (p_sample_rise) // (R1)
      else $error("input bit not sampled on rise");
   property p_tx_moves_on_fall;
      @(posedge clock) disable iff (!reset_n)
      $changed(tx_q) |-> $past(fr.sclk_fall || fr.cs_fall);
   endproperty
   a_tx_moves_on_fall: assert property (p_tx_moves_on_fall) // (R2)
      else $error("output register moved off a falling edge");
endmodule
`default_nettype wire

// *** design/squib_serial_port.sv ***
// squib driver serial command port: decode, response and fire gating
//
// Behaviour
// (R1) input bit is taken on every rising serial clock while selected
// (R2) output bit changes on every falling serial clock while selected
// (R3) chip select rising latches the received byte and applies it
// (R4) chip select falling loads the result byte into the shifter
// (R5) group one drivers only fire while its enable input is high
// (R6) group two drivers only fire while its own enable is high
// (R7) reset low disables functions and clears the shift registers
// (R8) frames are eight bits, most significant bit first
// (R9) bytes sent out carry the result of the previous command
// (R10) NOP or undefined code cancels diagnostics, held data goes out
// (R11) active diagnostic ends on the next valid command
// (R12) echo command returns the complement pattern next frame
// (R13) result bits without data read as zero
// (R14) only frames of exactly eight clocks take effect
// (R15) second programming byte is a NOP while any driver fires
// (R16) programming bytes must be in consecutive frames, else NOP
// (R17) clock level at select fall picks standard or alternate mode
// (R18) data output is high impedance while deselected
// (R19) identity reply bit 7 marks the four-channel variant
// (R20) low-side continuity held until sent, then cleared
// (R21) master pairs force and sense commands across two devices; the bench drives one device and sends no force command
// (R22) arm and fire commands are echoed next frame
// (R23) clock edges are ignored while chip select is high
`timescale 1ns/100ps
`default_nettype none
module squib_serial_port (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   // serial pins
   input  wire logic                  chip_select_n,
   input  wire logic                  serial_clock,
   input  wire logic                  serial_in_pin,
   output wire logic                  serial_out_pin,
   output wire logic                  serial_out_oe,
   // fire enables
   input  wire logic                  fire_enable_group_one,
   input  wire logic                  fire_enable_group_two,
   // diagnostic side
   input  wire squib_port_pkg::byte_t diag_result_in,
   input  wire squib_port_pkg::byte_t id_status_in,
   input  wire squib_port_pkg::chan_t loop_sense_input,
   output wire squib_port_pkg::byte_t diag_command,
   output wire logic                  diag_active,
   output wire logic                  alternate_serial_mode,
   output wire squib_port_pkg::chan_t fire_drive
);
   import squib_port_pkg::*;

   // ---------------------------------------------------------
   // command classes
   // ---------------------------------------------------------
   function automatic logic is_arm(input byte_t c);
      is_arm = (c == CMD_ARM_ONE) || (c == CMD_ARM_TWO)
            || (c == CMD_ARM_ALL);
   endfunction

   function automatic logic is_fire(input byte_t c);
      is_fire = (c[7:4] == FIRE_NIBBLE);
   endfunction

   function automatic logic is_diag(input byte_t c);
      is_diag = c inside {[DIAG_C_LO:DIAG_C_HI], CMD_ID_QUERY,
                          CMD_DIAG_C9, [DIAG_D_LO:DIAG_D_HI],
                          [DIAG_E_LO:DIAG_E_HI], CMD_DIAG_E8,
                          CMD_DIAG_E9};
   endfunction

   function automatic logic is_defined(input byte_t c);
      is_defined = is_arm(c) || is_fire(c) || is_diag(c)
                || (c == CMD_ECHO);
   endfunction

   // ---------------------------------------------------------
   // declarations
   // ---------------------------------------------------------
   logic [PIN_W-1:0] pin_lvl;
   logic             cs_lvl;
   logic             sclk_lvl;
   logic             fen_one_lvl;
   logic             fen_two_lvl;
   logic             cs_prev_q;
   logic             sclk_prev_q;
   logic             cs_fall;
   logic             cs_rise;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             frame_ok;
   logic             valid_frame;
   logic             fire_ok;
   logic             fire_block;
   byte_t            rx;
   byte_t            eff_cmd;
   byte_t            resp_byte;
   logic             resp_load;
   byte_t            prev_cmd_q;
   byte_t            prev_cmd_d;
   seq_state_t       seq_q;
   seq_state_t       seq_d;
   chan_t            arm_req;
   chan_t            arm_mask_q;
   chan_t            arm_mask_d;
   chan_t            fire_sel_q;
   chan_t            fire_sel_d;
   chan_t            fen_mask;
   chan_t            fire_drive_q;
   chan_t            cont_set;
   logic             cont_clr;
   chan_t            cont_q;
   chan_t            cont_d;
   logic             cont_sent_q;
   logic             cont_sent_d;
   byte_t            diag_cmd_q;
   byte_t            diag_cmd_d;
   logic             diag_active_q;
   logic             diag_active_d;
   logic             mode_q;
   logic             out_q;
   logic             oe_q;

   serial_frame_if fr ();

   // ---------------------------------------------------------
   // pin synchronisers and shift register
   // ---------------------------------------------------------
   pin_filter #(
      .W         (PIN_W),
      .RESET_VAL (PIN_RESET)
   ) u_pins (
      .clock     (clock),
      .reset_n   (reset_n),
      .pin_in    ({fire_enable_group_two, fire_enable_group_one,
                   serial_in_pin, serial_clock, chip_select_n}),
      .level_out (pin_lvl)
   );

   // (R7) (R8) shifters cleared by reset
   frame_shifter u_shift (
      .clock   (clock),
      .reset_n (reset_n),
      .fr      (fr.shifter)
   );

   assign cs_lvl      = pin_lvl[PIN_CS];
   assign sclk_lvl    = pin_lvl[PIN_SCLK];
   assign fen_one_lvl = pin_lvl[PIN_FEN_ONE];
   assign fen_two_lvl = pin_lvl[PIN_FEN_TWO];

   // ---------------------------------------------------------
   // edge detection
   // ---------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cs_prev_q   <= PIN_RESET[PIN_CS];
         sclk_prev_q <= PIN_RESET[PIN_SCLK];
      end else begin
         cs_prev_q   <= cs_lvl;
         sclk_prev_q <= sclk_lvl;
      end
   end

   assign cs_fall   = cs_prev_q & ~cs_lvl;
   assign cs_rise   = ~cs_prev_q & cs_lvl;
   // (R23) clock edges only while selected
   assign sclk_rise = ~sclk_prev_q & sclk_lvl & ~cs_lvl;
   assign sclk_fall = sclk_prev_q & ~sclk_lvl & ~cs_lvl;

   assign fr.sclk_rise = sclk_rise;
   assign fr.sclk_fall = sclk_fall;
   assign fr.cs_fall   = cs_fall;
   assign fr.mosi      = pin_lvl[PIN_MOSI];

   // ---------------------------------------------------------
   // frame check and command decode
   // ---------------------------------------------------------
   // (R14) exactly eight clocks
   assign frame_ok    = (fr.bit_count == CNT_FULL);
   assign valid_frame = cs_rise & frame_ok;
   assign rx          = fr.rx_byte;

   // (R15) (R16) fire needs arm just before, nothing firing
   assign fire_ok    = is_fire(rx) & (seq_q == SEQ_ARMED)
                     & ~(|fire_drive_q);
   assign fire_block = is_fire(rx) & ~fire_ok;
   assign eff_cmd    = fire_block ? CMD_NOP : rx;

   assign arm_req = (eff_cmd == CMD_ARM_ONE) ? GROUP_ONE
                  : (eff_cmd == CMD_ARM_TWO) ? GROUP_TWO
                  : (eff_cmd == CMD_ARM_ALL) ? CHAN_ALL
                  : CHAN_NONE;

   // (R3) all functions applied at select rise
   assign prev_cmd_d = valid_frame ? eff_cmd : prev_cmd_q;
   assign arm_mask_d = valid_frame ? arm_req : arm_mask_q;

   // (R16) any other frame, even a rejected one, breaks the pair
   assign seq_d = (valid_frame && is_arm(eff_cmd)) ? SEQ_ARMED
                : cs_rise ? SEQ_IDLE
                : seq_q;

   assign fire_sel_d = !valid_frame ? fire_sel_q
                     : fire_ok ? (rx[CHAN_W-1:0] & arm_mask_q)
                     : is_arm(eff_cmd) ? fire_sel_q
                     : CHAN_NONE;

   // (R10) (R11) diagnostics end on every valid command
   assign diag_cmd_d    = !valid_frame ? diag_cmd_q
                        : is_diag(eff_cmd) ? eff_cmd
                        : CMD_NOP;
   assign diag_active_d = valid_frame ? is_diag(eff_cmd)
                        : diag_active_q;

   // ---------------------------------------------------------
   // continuity latch
   // ---------------------------------------------------------
   // (R20) set wins over clear
   assign cont_set    = (diag_cmd_q == CMD_CONT) ? loop_sense_input
                      : CHAN_NONE;
   assign cont_clr    = valid_frame & cont_sent_q;
   assign cont_d      = (cont_clr ? CHAN_NONE : cont_q) | cont_set;
   assign cont_sent_d = (cs_fall && prev_cmd_q == CMD_CONT) ? 1'b1
                      : cont_clr ? 1'b0
                      : cont_sent_q;

   // ---------------------------------------------------------
   // response selection
   // ---------------------------------------------------------
   // (R9) (R10) result of previous command, held data otherwise
   assign resp_load = is_defined(prev_cmd_q);
   // (R12) (R13) (R19) (R22) response byte
   assign resp_byte =
        (prev_cmd_q == CMD_ECHO) ? ECHO_REPLY
      : (is_arm(prev_cmd_q) || is_fire(prev_cmd_q)) ? prev_cmd_q
      : (prev_cmd_q == CMD_ID_QUERY)
           ? {FOUR_CHANNEL_ID, id_status_in[ID_BIT_POS-1:0]}
      : (prev_cmd_q == CMD_CONT) ? {CHAN_NONE, cont_q}
      : diag_result_in;

   // (R4) loaded at select fall
   assign fr.load_en   = resp_load;
   assign fr.load_byte = resp_byte;

   // ---------------------------------------------------------
   // fire gating
   // ---------------------------------------------------------
   // (R5) (R6) each group gated by its own enable
   assign fen_mask = {{2{fen_two_lvl}}, {2{fen_one_lvl}}};

   // ---------------------------------------------------------
   // state registers
   // ---------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         prev_cmd_q <= CMD_NOP;
         seq_q      <= SEQ_IDLE;
         arm_mask_q <= CHAN_NONE;
         fire_sel_q <= CHAN_NONE;
      end else begin
         prev_cmd_q <= prev_cmd_d;
         seq_q      <= seq_d;
         arm_mask_q <= arm_mask_d;
         fire_sel_q <= fire_sel_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         diag_cmd_q    <= CMD_NOP;
         diag_active_q <= 1'b0;
         cont_q        <= CHAN_NONE;
         cont_sent_q   <= 1'b0;
      end else begin
         diag_cmd_q    <= diag_cmd_d;
         diag_active_q <= diag_active_d;
         cont_q        <= cont_d;
         cont_sent_q   <= cont_sent_d;
      end
   end

   // (R17) (R18) mode capture and output drive
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mode_q       <= 1'b0;
         out_q        <= 1'b0;
         oe_q         <= 1'b0;
         fire_drive_q <= CHAN_NONE;
      end else begin
         mode_q       <= cs_fall ? sclk_lvl : mode_q;
         out_q        <= ~cs_lvl & fr.tx_bit;
         oe_q         <= ~cs_lvl;
         fire_drive_q <= fire_sel_q & fen_mask;
      end
   end

   assign serial_out_pin        = out_q;
   assign serial_out_oe         = oe_q;
   assign alternate_serial_mode = mode_q;
   assign diag_command          = diag_cmd_q;
   assign diag_active           = diag_active_q;
   assign fire_drive            = fire_drive_q;

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   sequence s_frame_end;
      cs_rise && frame_ok;
   endsequence

   sequence s_short_frame;
      cs_rise && !frame_ok;
   endsequence

   property p_gate_one;
      @(posedge clock) disable iff (!reset_n)
      (|fire_drive_q[1:0]) |-> $past(fen_one_lvl);
   endproperty
   a_gate_one: assert property (p_gate_one) // (R5)
      else $error("group one fired without enable");

   property p_gate_two;
      @(posedge clock) disable iff (!reset_n)
      (|fire_drive_q[3:2]) |-> $past(fen_two_lvl);
   endproperty
   a_gate_two: assert property (p_gate_two) // (R6)
      else $error("group two fired without enable");

   property p_hiz_deselected;
      @(posedge clock) disable iff (!reset_n)
      cs_lvl |=> !oe_q && !out_q;
   endproperty
   a_hiz_deselected: assert property (p_hiz_deselected) // (R18)
      else $error("output driven while deselected");

   property p_mode_capture;
      @(posedge clock) disable iff (!reset_n)
      cs_fall |=> mode_q == $past(sclk_lvl);
   endproperty
   a_mode_capture: assert property (p_mode_capture) // (R17)
      else $error("mode not taken from clock level");

   property p_short_ignored;
      @(posedge clock) disable iff (!reset_n)
      s_short_frame |=> $stable(prev_cmd_q) && $stable(diag_cmd_q);
   endproperty
   a_short_ignored: assert property (p_short_ignored) // (R14)
      else $error("malformed frame took effect");

   property p_latch_rise;
      @(posedge clock) disable iff (!reset_n)
      s_frame_end ##0 !is_fire(rx) |=> prev_cmd_q == $past(rx);
   endproperty
   a_latch_rise: assert property (p_latch_rise) // (R3)
      else $error("command not latched at select rise");

   property p_diag_cleared;
      @(posedge clock) disable iff (!reset_n)
      s_frame_end ##0 !is_diag(rx) |=> !diag_active_q;
   endproperty
   a_diag_cleared: assert property (p_diag_cleared) // (R11)
      else $error("diagnostic survived next command");

   property p_echo_reply;
      @(posedge clock) disable iff (!reset_n)
      cs_fall && prev_cmd_q == CMD_ECHO |-> ##2 out_q == 1'b0;
   endproperty
   a_echo_reply: assert property (p_echo_reply) // (R12)
      else $error("echo reply first bit wrong");

   property p_id_bit;
      @(posedge clock) disable iff (!reset_n)
      cs_fall && prev_cmd_q == CMD_ID_QUERY
         |-> ##2 out_q == FOUR_CHANNEL_ID;
   endproperty
   a_id_bit: assert property (p_id_bit) // (R19)
      else $error("identity bit wrong");

   property p_fire_needs_arm;
      @(posedge clock) disable iff (!reset_n)
      $changed(fire_sel_q) && (|fire_sel_q)
         |-> $past(seq_q) == SEQ_ARMED;
   endproperty
   a_fire_needs_arm: assert property (p_fire_needs_arm) // (R16)
      else $error("fire taken without arm just before");

   property p_no_fire_while_firing;
      @(posedge clock) disable iff (!reset_n)
      s_frame_end ##0 is_fire(rx) && (|fire_drive_q)
         |=> prev_cmd_q == CMD_NOP;
   endproperty
   a_no_fire_while_firing: assert property (p_no_fire_while_firing) // (R15)
      else $error("fire byte accepted while firing");
endmodule
`default_nettype wire

// *** tb/spi_master_model.sv ***
// serial bus master model for the squib command port
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
   // clock
   input  wire logic clock,
   // serial pins
   input  wire logic miso,
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic mosi
);
   import squib_port_pkg::*;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic frame(input byte_t tx, input int nbits, input logic idle,
                        output byte_t rx);
      rx = 8'h00;
      sclk <= idle;
      wait_clk(6);
      cs_n <= 1'b0;
      wait_clk(10);
      for (int i = 0; i < nbits; i++) begin
         sclk <= 1'b0;
         mosi <= (i < 8) ? tx[7-i] : 1'b0;
         wait_clk(4);
         sclk <= 1'b1;
         wait_clk(4);
         rx = {rx[6:0], miso};
      end
      sclk <= 1'b0;
      wait_clk(4);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      wait_clk(8);
   endtask
endmodule
`default_nettype wire

// *** tb/test_squib_driver_serial_command_port.sv ***
// self-checking bench for the squib serial command port
`timescale 1ns/100ps
`default_nettype none
module test_squib_driver_serial_command_port;
   import squib_port_pkg::*;
   logic        clock      = 1'b0;
   logic        reset_n    = 1'b0;
   logic        en_one     = 1'b0;
   logic        en_two     = 1'b0;
   byte_t       diag_res   = 8'h00;
   byte_t       id_stat    = 8'h00;
   chan_t       sense      = 4'h0;
   logic [15:0] seed       = 16'h0013;
   int          mismatches = 0;
   int          checks     = 0;
   logic        cs_n, sclk, mosi, sdo, sdo_oe, act, alt;
   byte_t       dcmd, rx, exp_b;
   chan_t       drive;
   byte_t       codes[9]   = '{DIAG_C_LO, DIAG_C_HI, CMD_DIAG_C9, DIAG_D_LO,
      DIAG_D_HI, DIAG_E_LO, DIAG_E_HI, CMD_DIAG_E8, CMD_DIAG_E9};
   byte_t       arms[3]    = '{CMD_ARM_ONE, CMD_ARM_TWO, CMD_ARM_ALL};
   always #4 clock = ~clock;
   spi_master_model mst_u (.clock(clock), .miso(sdo), .cs_n(cs_n),
      .sclk(sclk), .mosi(mosi));
   squib_serial_port dut_u (.clock(clock), .reset_n(reset_n),
      .chip_select_n(cs_n), .serial_clock(sclk), .serial_in_pin(mosi),
      .serial_out_pin(sdo), .serial_out_oe(sdo_oe),
      .fire_enable_group_one(en_one), .fire_enable_group_two(en_two),
      .diag_result_in(diag_res), .id_status_in(id_stat),
      .loop_sense_input(sense), .diag_command(dcmd), .diag_active(act),
      .alternate_serial_mode(alt), .fire_drive(drive));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic next_rand;
      seed = lfsr(seed);
   endtask
   function automatic chan_t fire_exp(input int g, input chan_t nib,
                                      input logic [1:0] en);
      chan_t grp[3] = '{GROUP_ONE, GROUP_TWO, CHAN_ALL};
      return nib & grp[g] & {{2{en[1]}}, {2{en[0]}}};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic fr(input byte_t c, input int n = 8);
      mst_u.frame(c, n, 1'b0, rx);
   endtask
   task automatic close_out;
      if (mismatches == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      close_out();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      check({drive, 3'h0, sdo_oe}, 8'h00);
      fr(CMD_ECHO);
      fr(CMD_NOP);
      check(rx, ECHO_REPLY);
      check({7'h00, sdo_oe}, 8'h00);
      fr(CMD_NOP);
      check(rx, ECHO_REPLY);
      check({7'h00, act}, 8'h00);
      next_rand;
      id_stat <= seed[7:0];
      fr(CMD_ID_QUERY);
      fr(CMD_NOP);
      check(rx, {1'b0, seed[6:0]});
      foreach (codes[i]) begin
         fr(codes[i]);
         check(dcmd, codes[i]);
         check({7'h00, act}, 8'h01);
         if (i > 0) check(rx, exp_b);
         next_rand;
         diag_res <= seed[7:0];
         exp_b = seed[7:0];
      end
      sense <= seed[3:0];
      // low-side continuity command with loop sense driven from the seed
      fr(CMD_CONT);
      check(rx, exp_b);
      sense <= 4'h0;
      fr(CMD_ECHO);
      check(rx, {4'h0, seed[3:0]});
      fr(CMD_CONT);
      fr(CMD_NOP);
      check(rx, 8'h00);
      for (int i = 0; i < 4; i++) begin
         next_rand;
         en_one <= i[0];
         en_two <= i[1];
         fr(arms[i%3]);
         fr({FIRE_NIBBLE, seed[3:0]});
         check(rx, arms[i%3]);
         check({4'h0, drive}, {4'h0, fire_exp(i%3, seed[3:0], i[1:0])});
         en_one <= 1'b0;
         repeat (10) @(posedge clock);
         check({4'h0, drive}, {4'h0, fire_exp(i%3, seed[3:0], {i[1], 1'b0})});
         fr(CMD_NOP);
         check(rx, {FIRE_NIBBLE, seed[3:0]});
      end
      en_one <= 1'b1;
      fr(DIAG_E_LO);
      fr(CMD_ID_QUERY, 7);
      check(dcmd, DIAG_E_LO);
      fr(CMD_ARM_ALL);
      fr(8'h5F, 9);
      fr(8'h5F);
      check({4'h0, drive}, 8'h00);
      fr(CMD_ARM_ALL);
      fr(CMD_NOP);
      fr(8'h5F);
      check({4'h0, drive}, 8'h00);
      fr(CMD_ARM_ALL);
      fr(8'h53);
      fr(CMD_ARM_ALL);
      fr(8'h5C);
      check({4'h0, drive & GROUP_TWO}, 8'h00);
      mst_u.frame(CMD_ECHO, 8, 1'b1, rx);
      check({7'h00, alt}, 8'h01);
      fr(CMD_NOP);
      check(rx, ECHO_REPLY);
      check({7'h00, alt}, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
